// ### common/lapm_pkg.sv
// Constants and types shared by the loss, alarm and pattern monitor
package lapm_pkg;
   // ==========================================================
   // Register offsets and reset values
   localparam logic [7:0] LAPM_RECEIVE_CONFIG_ONE_OFS = 8'h0B;
   localparam logic [7:0] LAPM_MAINTENANCE_CONTROL_ZERO_OFS = 8'h0D;
   localparam logic [7:0] LAPM_LINE_STATUS_ZERO_OFS = 8'h17;
   localparam logic [7:0] LAPM_RECEIVE_CONFIG_ONE_RST = 8'h00;
   localparam logic [7:0] LAPM_MAINTENANCE_CONTROL_ZERO_RST = 8'h00;
   // ==========================================================
   // Field positions
   localparam int LAPM_RCF_LVL_LSB = 0;
   localparam int LAPM_RCF_EQ_BIT = 5;
   localparam int LAPM_MT_PATT_LSB = 0;
   localparam int LAPM_MT_PCLK_BIT = 2;
   localparam int LAPM_MT_INV_BIT = 3;
   localparam int LAPM_MT_LAC_BIT = 4;
   localparam int LAPM_MT_SYSAIS_BIT = 5;
   localparam int LAPM_MT_LINEAIS_BIT = 6;
   localparam int LAPM_ST_LOS_BIT = 0;
   localparam int LAPM_ST_AIS_BIT = 1;
   localparam int LAPM_ST_SYNC_BIT = 2;
   // ==========================================================
   // Bit interval counts, level code limit and FIFO depth
   localparam logic [11:0] LAPM_LOS_N_SHORT = 12'd32;
   localparam logic [11:0] LAPM_LOS_N_LONG = 12'd2048;
   localparam logic [5:0] LAPM_LOS_M_LAST = 6'd31;
   localparam logic [5:0] LAPM_LOS_MARK_MIN = 6'd4;
   localparam logic [4:0] LAPM_LOS_ZRUN_MAX = 5'd16;
   localparam logic [8:0] LAPM_AIS_BLK_LAST = 9'd511;
   localparam logic [1:0] LAPM_AIS_ZMIN = 2'd3;
   localparam logic [5:0] LAPM_PW_LAST = 6'd63;
   localparam logic [6:0] LAPM_PW_MAXERR = 7'd6;
   localparam logic [4:0] LAPM_LVL_MAX = 5'h0A;
   localparam int LAPM_FIFO_DEPTH = 16;
   // ==========================================================
   // Modes and states
   typedef enum logic [1:0]
   {
      LAPM_PAT_NORM = 2'b00,
      LAPM_PAT_ONES = 2'b01,
      LAPM_PAT_PRBS = 2'b10,
      LAPM_PAT_RSV = 2'b11
   } lapm_patt_t;
   typedef enum logic [0:0]
   {
      LAPM_SIG_OK = 1'b0,
      LAPM_SIG_LOST = 1'b1
   } lapm_los_t;
endpackage

// ### logic/lapm_fifo.sv
// Small flop-based FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lapm_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign in_ready = (wr_r - rd_r) != (AW + 1)'(DEPTH);
   assign out_valid = wr_r != rd_r;
   assign out_data = mem_r[rd_r[AW-1:0]];
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_r <= '0;
         rd_r <= '0;
         for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
      end
      else
      begin
         if (push) mem_r[wr_r[AW-1:0]] <= in_data;
         if (push) wr_r <= wr_r + 1'b1;
         if (pop) rd_r <= rd_r + 1'b1;
      end
   end
endmodule // lapm_fifo
`default_nettype wire

// ### logic/lapm_monitor.sv
// Loss-of-signal, alarm signal and internal pattern monitor
// What this block does
// RL1 - Declare loss after 32 or 2048 low intervals
// RL2 - Clear after good 32-bit window from pulse
// RL3 - Loss raises interrupt unless masked
// RL4 - No loss indication in line monitor mode
// RL5 - Equalizer off: fixed declare and clear thresholds
// RL6 - Equalizer on: level field sets declare threshold
// RL7 - Pin control keeps equalizer off
// RL8 - System side all ones on master clock
// RL9 - Line side all ones on master clock
// RL10 - Loss indication unaffected by any loopback
// RL11 - Alarm detection only with clock recovery on
// RL12 - Criteria 0: two consecutive 512-bit blocks
// RL13 - Criteria 1: one 512-bit block decides
// RL14 - Pattern clock: transmit clock or master clock
// RL15 - Pattern 00: normal, or zeros on master
// RL16 - Pattern 01: all ones to line
// RL17 - Pattern 10: pseudo-random sequence, true or inverted
// RL18 - Pin control uses same pattern encoding
// RL19 - Detect received sequence, report sync status
// RL20 - Sync held while 64-bit window errors <= 6
// RL21 - Invert generated and compared sequence
// RL22 - Latch sync changes, interrupt when enabled
// RL23 - Sequence is x^15 + x^14 + 1 register
// RL24 - Count on receive bit ticks, restart on break
`timescale 1ns/1ps
`default_nettype none
module lapm_monitor
   import lapm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   output logic [7:0] reg_rdata,
   input wire logic hw_mode_pin,
   input wire logic [1:0] hw_pattern_pin,
   input wire logic line_monitor_mode,
   input wire logic cdr_enable,
   input wire logic los_irq_mask,
   input wire logic sequence_event_edge_select,
   input wire logic sequence_event_mask,
   input wire logic sequence_event_clear,
   input wire logic rx_bit_tick,
   input wire logic rx_pos,
   input wire logic rx_neg,
   input wire logic amp_below_q,
   input wire logic amp_above_p,
   input wire logic transmit_clock_tick,
   input wire logic master_clock_tick,
   input wire logic tx_in_valid,
   output logic tx_in_ready,
   input wire logic tx_in_data,
   output logic loss_out,
   output logic los_irq,
   output logic seq_irq,
   output logic eq_enable,
   output logic thr_fixed,
   output logic [4:0] thr_code,
   output logic receive_data_positive,
   output logic receive_data_negative,
   output logic rx_out_tick,
   output logic tx_line_bit,
   output logic tx_line_valid
);
   // ==========================================================
   // Registers and pin synchronisers
   logic [7:0] receive_config_one_r;
   logic [7:0] maintenance_control_zero_r;
   logic [2:0] hw_s1_r;
   logic [2:0] hw_s2_r;
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         receive_config_one_r <= LAPM_RECEIVE_CONFIG_ONE_RST;
         maintenance_control_zero_r <= LAPM_MAINTENANCE_CONTROL_ZERO_RST;
         hw_s1_r <= '0;
         hw_s2_r <= '0;
      end
      else
      begin
         if (reg_wr && reg_addr == LAPM_RECEIVE_CONFIG_ONE_OFS) receive_config_one_r <= reg_wdata;
         if (reg_wr && reg_addr == LAPM_MAINTENANCE_CONTROL_ZERO_OFS) maintenance_control_zero_r <= reg_wdata;
         hw_s1_r <= {hw_mode_pin, hw_pattern_pin};
         hw_s2_r <= hw_s1_r;
      end
   end
   wire hw_mode = hw_s2_r[2];
   wire loss_criteria_select = maintenance_control_zero_r[LAPM_MT_LAC_BIT];
   wire seq_inv = maintenance_control_zero_r[LAPM_MT_INV_BIT];
   wire pclk_sel = maintenance_control_zero_r[LAPM_MT_PCLK_BIT];
   wire sys_ones_en = maintenance_control_zero_r[LAPM_MT_SYSAIS_BIT];
   wire line_ones_en = maintenance_control_zero_r[LAPM_MT_LINEAIS_BIT];
   wire [1:0] patt_reg = maintenance_control_zero_r[LAPM_MT_PATT_LSB +: 2];
   wire [1:0] patt_sel = hw_mode ? hw_s2_r[1:0] : patt_reg; // see RL18
   wire [4:0] lvl = receive_config_one_r[LAPM_RCF_LVL_LSB +: 5];
   // Reserved level codes clamp to the deepest legal step
   assign eq_enable = receive_config_one_r[LAPM_RCF_EQ_BIT] & ~hw_mode; // see RL7
   assign thr_fixed = ~eq_enable; // see RL5
   assign thr_code = (lvl > LAPM_LVL_MAX) ? LAPM_LVL_MAX : lvl; // see RL6
   wire rx_mark = rx_pos | rx_neg;
   // ==========================================================
   // Loss of signal
   lapm_los_t los_st_r;
   lapm_los_t los_st_nxt;
   logic [11:0] dcnt_r;
   logic [5:0] ccnt_r;
   logic [5:0] marks_r;
   logic [4:0] zrun_r;
   logic loss_r;
   wire below = amp_below_q & ~rx_mark;
   wire [11:0] los_n = loss_criteria_select ? LAPM_LOS_N_LONG : LAPM_LOS_N_SHORT;
   wire [11:0] dcnt_nxt = below ? dcnt_r + 12'd1 : 12'd0; // see RL24
   // At-or-above so a criteria change in mid-silence still declares
   wire declare_hit = rx_bit_tick & (dcnt_nxt >= los_n); // see RL1
   wire win_idle = ccnt_r == 6'd0;
   wire win_start = win_idle & rx_mark & amp_above_p;
   wire [4:0] zrun_nxt = rx_mark ? 5'd0 : zrun_r + 5'd1;
   wire [5:0] marks_nxt = marks_r + {5'd0, rx_mark};
   wire win_break = (rx_mark & ~amp_above_p) | (zrun_nxt == LAPM_LOS_ZRUN_MAX);
   wire win_done = ~win_idle & ~win_break & (ccnt_r == LAPM_LOS_M_LAST);
   wire clear_hit = rx_bit_tick & win_done & (marks_nxt >= LAPM_LOS_MARK_MIN); // see RL2
   always_comb
   begin
      los_st_nxt = los_st_r;
      case (los_st_r)
         LAPM_SIG_OK: if (declare_hit) los_st_nxt = LAPM_SIG_LOST;
         LAPM_SIG_LOST: if (clear_hit) los_st_nxt = LAPM_SIG_OK;
         default: los_st_nxt = LAPM_SIG_OK;
      endcase
   end
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         los_st_r <= LAPM_SIG_OK;
         dcnt_r <= '0;
         ccnt_r <= '0;
         marks_r <= '0;
         zrun_r <= '0;
         loss_r <= 1'b0;
      end
      else
      begin
         los_st_r <= los_st_nxt;
         // Loopback state is deliberately not an input here
         loss_r <= (los_st_nxt == LAPM_SIG_LOST) & ~line_monitor_mode; // see RL4 RL10
         if (rx_bit_tick)
         begin
            dcnt_r <= (los_st_r == LAPM_SIG_OK) ? dcnt_nxt : 12'd0;
            if (los_st_r != LAPM_SIG_LOST || win_done || (~win_idle && win_break))
               ccnt_r <= 6'd0; // see RL24
            else if (win_start)
               ccnt_r <= 6'd1;
            else if (!win_idle)
               ccnt_r <= ccnt_r + 6'd1;
            marks_r <= win_idle ? {5'd0, win_start} : marks_nxt;
            zrun_r <= win_idle ? 5'd0 : zrun_nxt;
         end
      end
   end
   assign loss_out = loss_r;
   assign los_irq = loss_r & ~los_irq_mask; // see RL3
   // ==========================================================
   // Alarm indication signal
   logic [8:0] bcnt_r;
   logic [1:0] zeros_r;
   logic prev_low_r;
   logic ais_r;
   wire [1:0] zeros_nxt = (!rx_mark && zeros_r != LAPM_AIS_ZMIN) ? zeros_r + 2'd1 : zeros_r;
   wire blk_end = rx_bit_tick & (bcnt_r == LAPM_AIS_BLK_LAST);
   wire blk_low = zeros_nxt < LAPM_AIS_ZMIN;
   wire ais_set = loss_criteria_select ? blk_low : (blk_low & prev_low_r); // see RL12 RL13
   wire ais_clr = loss_criteria_select ? ~blk_low : (~blk_low & ~prev_low_r);
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bcnt_r <= '0;
         zeros_r <= '0;
         prev_low_r <= 1'b0;
         ais_r <= 1'b0;
      end
      else if (!cdr_enable)
      begin
         bcnt_r <= '0; // see RL11
         zeros_r <= '0;
         prev_low_r <= 1'b0;
         ais_r <= 1'b0;
      end
      else if (rx_bit_tick)
      begin
         bcnt_r <= bcnt_r + 9'd1;
         zeros_r <= blk_end ? 2'd0 : zeros_nxt;
         if (blk_end)
         begin
            prev_low_r <= blk_low;
            if (ais_set) ais_r <= 1'b1;
            else if (ais_clr) ais_r <= 1'b0;
         end
      end
   end
   // ==========================================================
   // Sequence checker, self-synchronising on received bits
   logic [14:0] chk_hist_r;
   logic [5:0] wcnt_r;
   logic [6:0] ecnt_r;
   logic sync_r;
   logic seq_evt_r;
   wire rx_cmp = rx_mark ^ seq_inv; // see RL21
   wire bit_err = rx_cmp ^ (chk_hist_r[14] ^ chk_hist_r[13]); // see RL23
   wire [6:0] ecnt_nxt = ecnt_r + {6'd0, bit_err};
   wire win_end = rx_bit_tick & (wcnt_r == LAPM_PW_LAST);
   // Tolerates up to 6 in 64 bit errors, just under one in ten
   wire sync_nxt = win_end ? (ecnt_nxt <= LAPM_PW_MAXERR) : sync_r; // see RL19 RL20
   wire sync_chg = sync_nxt != sync_r;
   wire evt_set = sync_chg & (sequence_event_edge_select | sync_nxt); // see RL22
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         chk_hist_r <= '0;
         wcnt_r <= '0;
         ecnt_r <= '0;
         sync_r <= 1'b0;
         seq_evt_r <= 1'b0;
      end
      else
      begin
         if (rx_bit_tick)
         begin
            chk_hist_r <= {chk_hist_r[13:0], rx_cmp};
            wcnt_r <= wcnt_r + 6'd1;
            ecnt_r <= win_end ? 7'd0 : ecnt_nxt;
         end
         sync_r <= sync_nxt;
         // A change landing on the clear cycle is kept
         seq_evt_r <= evt_set | (seq_evt_r & ~sequence_event_clear);
      end
   end
   assign seq_irq = seq_evt_r & sequence_event_mask; // see RL22
   // ==========================================================
   // Receive outputs toward the system side
   logic rdp_r;
   logic rdn_r;
   logic rtick_r;
   wire sys_ones = loss_r & sys_ones_en; // see RL8
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdp_r <= 1'b0;
         rdn_r <= 1'b0;
         rtick_r <= 1'b0;
      end
      else
      begin
         rtick_r <= sys_ones ? master_clock_tick : rx_bit_tick;
         rdp_r <= sys_ones ? 1'b1 : rx_pos;
         rdn_r <= sys_ones ? 1'b0 : rx_neg;
      end
   end
   assign receive_data_positive = rdp_r;
   assign receive_data_negative = rdn_r;
   assign rx_out_tick = rtick_r;
   // ==========================================================
   // Transmit pattern selection
   logic [14:0] gen_r;
   logic txb_r;
   logic txv_r;
   logic fifo_valid;
   logic fifo_data;
   wire line_ones = loss_r & line_ones_en; // see RL9
   wire pat_tick = pclk_sel ? master_clock_tick : transmit_clock_tick; // see RL14
   wire is_norm = patt_sel != LAPM_PAT_ONES && patt_sel != LAPM_PAT_PRBS;
   wire is_zeros = patt_sel == LAPM_PAT_NORM && pclk_sel; // see RL15
   wire pass_thru = is_norm & ~is_zeros & ~line_ones;
   wire out_tick = line_ones ? master_clock_tick : (pass_thru ? transmit_clock_tick : pat_tick);
   wire gen_bit = gen_r[14] ^ seq_inv; // see RL17 RL21
   wire gen_step = out_tick & ~line_ones & (patt_sel == LAPM_PAT_PRBS);
   wire fifo_pop = out_tick & pass_thru;
   logic tx_bit_sel;
   always_comb
   begin
      if (line_ones) tx_bit_sel = 1'b1;
      else if (patt_sel == LAPM_PAT_ONES) tx_bit_sel = 1'b1; // see RL16
      else if (patt_sel == LAPM_PAT_PRBS) tx_bit_sel = gen_bit;
      else if (is_zeros) tx_bit_sel = 1'b0;
      else tx_bit_sel = fifo_valid & fifo_data; // Underrun sends a space
   end
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gen_r <= 15'h7FFF;
         txb_r <= 1'b0;
         txv_r <= 1'b0;
      end
      else
      begin
         if (gen_step) gen_r <= {gen_r[13:0], gen_r[14] ^ gen_r[13]}; // see RL23
         txv_r <= out_tick;
         if (out_tick) txb_r <= tx_bit_sel;
      end
   end
   assign tx_line_bit = txb_r;
   assign tx_line_valid = txv_r;
   lapm_fifo #(.WIDTH(1), .DEPTH(LAPM_FIFO_DEPTH)) u_tx_fifo (
      .core_clk(core_clk),
      .rstn(rstn),
      .in_valid(tx_in_valid),
      .in_ready(tx_in_ready),
      .in_data(tx_in_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );
   // ==========================================================
   // Register read
   wire [7:0] line_status_zero = {5'd0, sync_r, ais_r, loss_r};
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn) reg_rdata <= '0;
      else if (reg_addr == LAPM_RECEIVE_CONFIG_ONE_OFS) reg_rdata <= receive_config_one_r;
      else if (reg_addr == LAPM_MAINTENANCE_CONTROL_ZERO_OFS) reg_rdata <= maintenance_control_zero_r;
      else if (reg_addr == LAPM_LINE_STATUS_ZERO_OFS) reg_rdata <= line_status_zero; // see RL11
      else reg_rdata <= '0;
   end
   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   chk_los_short_declare: assert property ( // see RL1
      !loss_criteria_select && los_st_r == LAPM_SIG_OK && rx_bit_tick && below && dcnt_r == 12'd31
      |=> los_st_r == LAPM_SIG_LOST) else $error("loss not declared after 32");
   chk_los_clear_window: assert property ( // see RL2
      $fell(los_st_r) |-> $past(ccnt_r) == LAPM_LOS_M_LAST)
      else $error("loss cleared outside a full window");
   chk_los_irq_out: assert property ( // see RL3
      loss_out && !los_irq_mask |-> los_irq) else $error("loss interrupt missing");
   chk_los_monitor_off: assert property ( // see RL4
      line_monitor_mode |=> !loss_out) else $error("loss shown in monitor mode");
   chk_ais_cdr_gate: assert property ( // see RL11
      !cdr_enable |=> !ais_r) else $error("alarm without clock recovery");
   chk_ais_block_edge: assert property ( // see RL12
      $rose(ais_r) |-> $past(bcnt_r) == LAPM_AIS_BLK_LAST) else $error("alarm off block edge");
   chk_sys_ones_out: assert property ( // see RL8
      loss_r && sys_ones_en && master_clock_tick |=> rx_out_tick && receive_data_positive)
      else $error("system ones missing");
   chk_line_ones_out: assert property ( // see RL9
      loss_r && line_ones_en && master_clock_tick |=> tx_line_valid && tx_line_bit)
      else $error("line ones missing");
   chk_sync_window_end: assert property ( // see RL20
      sync_r != $past(sync_r) |-> $past(wcnt_r) == LAPM_PW_LAST) else $error("sync off window");
   chk_evt_set_wins: assert property ( // see RL22
      evt_set && sequence_event_clear |=> seq_evt_r) else $error("sync event lost");
   cov_los_declare: cover property ($rose(loss_out));
   cov_los_clear: cover property ($fell(loss_out));
   cov_ais_rise: cover property ($rose(ais_r));
   cov_sync_rise: cover property ($rose(sync_r));
endmodule // lapm_monitor
`default_nettype wire

// ### verif/lapm_line_model.sv
// Far-side model: E1 receive line, bit clocks and transmit loopback
`timescale 1ns/1ps
`default_nettype none
module lapm_line_model
(
   input wire logic core_clk,
   input wire logic [1:0] lmode,
   input wire logic tx_line_bit,
   input wire logic tx_line_valid,
   output logic rx_bit_tick,
   output logic rx_pos,
   output logic rx_neg,
   output logic amp_below_q,
   output logic amp_above_p,
   output logic transmit_clock_tick,
   output logic master_clock_tick
);
   // ==========================================
   // Modes: 0 silent line, 1 all marks, 2 transmit looped back
   logic [1:0] ph = 2'd0;
   logic pol = 1'b0;
   logic tk;
   logic mk;
   // Rails toggle between ticks so a stale value is never taken for data
   always @(negedge core_clk)
   begin
      ph <= ph + 2'd1;
      tk = (lmode == 2'd2) ? tx_line_valid : (ph == 2'd0);
      mk = (lmode == 2'd2) ? tx_line_bit : (lmode == 2'd1);
      transmit_clock_tick <= (ph == 2'd1);
      master_clock_tick <= (ph == 2'd3);
      amp_below_q <= (lmode == 2'd0);
      amp_above_p <= (lmode != 2'd0);
      rx_bit_tick <= tk;
      rx_pos <= tk ? (mk & ~pol) : ph[0];
      rx_neg <= tk ? (mk & pol) : ~ph[0];
      if (tk & mk)
         pol <= ~pol;
   end
endmodule // lapm_line_model
`default_nettype wire

// ### verif/test_lapm_monitor.sv
// Self-checking testbench for the loss, alarm and pattern monitor
`timescale 1ns/1ps
`default_nettype none
module test_lapm_monitor
   import lapm_pkg::*;
   ;
   logic core_clk, rstn, reg_wr, hw_mode_pin, line_monitor_mode, cdr_enable, los_irq_mask;
   logic sequence_event_edge_select, sequence_event_mask, sequence_event_clear;
   logic rx_bit_tick, rx_pos, rx_neg, amp_below_q, amp_above_p, transmit_clock_tick;
   logic master_clock_tick, tx_in_valid, tx_in_ready, tx_in_data, loss_out, los_irq;
   logic seq_irq, eq_enable, thr_fixed, receive_data_positive, receive_data_negative;
   logic rx_out_tick, tx_line_bit, tx_line_valid, inv, e, acc;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v, d;
   logic [4:0] thr_code;
   logic [1:0] hw_pattern_pin, lmode;
   logic [14:0] hist;
   logic q[$];
   int fail_count = 0, n_tests = 0, ek = -1, rk = -1, nh = 0, i, n;
   lapm_monitor u_dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
      .hw_mode_pin, .hw_pattern_pin, .line_monitor_mode, .cdr_enable, .los_irq_mask,
      .sequence_event_edge_select, .sequence_event_mask, .sequence_event_clear,
      .rx_bit_tick, .rx_pos, .rx_neg, .amp_below_q, .amp_above_p, .transmit_clock_tick,
      .master_clock_tick, .tx_in_valid, .tx_in_ready, .tx_in_data, .loss_out, .los_irq,
      .seq_irq, .eq_enable, .thr_fixed, .thr_code, .receive_data_positive,
      .receive_data_negative, .rx_out_tick, .tx_line_bit, .tx_line_valid);
   lapm_line_model u_line (.core_clk, .lmode, .tx_line_bit, .tx_line_valid, .rx_bit_tick,
      .rx_pos, .rx_neg, .amp_below_q, .amp_above_p, .transmit_clock_tick,
      .master_clock_tick);
   // ==========================================
   // Clock, compare and bus tasks
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic cmp(input string nm, input logic [7:0] ex, input logic [7:0] got);
      n_tests++;
      if (got !== ex)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic results;
      $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Writes land just after a transmit tick so no pattern bit straddles the change
   task automatic wr(input logic [7:0] a, input logic [7:0] dd);
      do @(posedge core_clk); while (transmit_clock_tick !== 1'b1);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = dd;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge core_clk);
      reg_addr = a;
      @(negedge core_clk);
      v = reg_rdata;
   endtask
   task automatic setp(input logic [7:0] dd, input int k);
      wr(LAPM_MAINTENANCE_CONTROL_ZERO_OFS, dd);
      ek = k;
      nh = 0;
      inv = dd[3];
      repeat (160) @(posedge core_clk);
   endtask
   task automatic ticks(input int k);
      repeat (k) do @(posedge core_clk); while (rx_bit_tick !== 1'b1);
   endtask
   // ==========================================
   // Reference model of the line output and receive outputs
   always @(posedge core_clk)
   begin
      if (tx_line_valid === 1'b1 && ek >= 0)
      begin
         e = (ek == 0);
         if (ek == 2)
            e = (q.size() > 0) ? q.pop_front() : 1'b0;
         if (ek == 3)
            e = hist[13] ^ hist[14] ^ inv;
         if (ek != 3 || nh >= 15)
            cmp("tx_line_bit", {7'd0, e}, {7'd0, tx_line_bit});
         hist = {hist[13:0], tx_line_bit};
         nh++;
      end
      if (rx_out_tick === 1'b1 && rk >= 0)
         cmp("rx_mark", rk[7:0], {7'd0, receive_data_positive | receive_data_negative});
   end
   initial
   begin
      #1_000_000;
      fail_count++;
      results();
   end
   // ==========================================
   // Main sequence
   initial
   begin
      void'($urandom(78707));
      {rstn, reg_wr, hw_mode_pin, line_monitor_mode, los_irq_mask, tx_in_valid} = 6'h00;
      {sequence_event_edge_select, sequence_event_mask, sequence_event_clear} = 3'h0;
      {reg_addr, reg_wdata, hw_pattern_pin, tx_in_data, inv, hist} = 0;
      cdr_enable = 1'b1;
      lmode = 2'd1;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rstn = 1'b1;
      rd(LAPM_RECEIVE_CONFIG_ONE_OFS);
      cmp("receive_config_one_reset", LAPM_RECEIVE_CONFIG_ONE_RST, v);
      rd(LAPM_MAINTENANCE_CONTROL_ZERO_OFS);
      cmp("maintenance_control_zero_reset", LAPM_MAINTENANCE_CONTROL_ZERO_RST, v);
      wr(LAPM_LINE_STATUS_ZERO_OFS, 8'hFF);
      rd(LAPM_LINE_STATUS_ZERO_OFS);
      cmp("line_status_zero_ro", 8'h00, v);
      rd(8'h00);
      cmp("unmapped", 8'h00, v);
      for (i = 0; i < 2; i++)
      begin
         d = 8'($urandom);
         d[5] = i[0];
         wr(LAPM_RECEIVE_CONFIG_ONE_OFS, d);
         rd(LAPM_RECEIVE_CONFIG_ONE_OFS);
         cmp("receive_config_one", d, v);
         cmp("eq_enable", {7'd0, d[5]}, {7'd0, eq_enable});
         cmp("thr_fixed", {7'd0, ~d[5]}, {7'd0, thr_fixed});
         cmp("thr_code", (d[4:0] > LAPM_LVL_MAX) ? 8'h0A : {3'd0, d[4:0]}, {3'd0, thr_code});
      end
      hw_mode_pin = 1'b1;
      repeat (4) @(negedge core_clk);
      cmp("eq_pin_mode", 8'h00, {7'd0, eq_enable});
      hw_mode_pin = 1'b0;
      // Buffer fills while the ones pattern holds the drain off
      setp(8'h01, 0);
      n = 0;
      acc = 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(negedge core_clk);
         if (acc)
            tx_in_data = 1'($urandom);
         tx_in_valid = 1'b1;
         @(posedge core_clk);
         acc = tx_in_ready;
         if (acc)
            q.push_back(tx_in_data);
         n += int'(acc);
      end
      @(negedge core_clk);
      tx_in_valid = 1'b0;
      cmp("fifo_depth", 8'd16, n[7:0]);
      setp(8'h00, 2);
      for (i = 0; i < 6; i++)
         setp(i[0] ? 8'h05 : 8'h04, i[0] ? 0 : 1);
      setp(8'h02, 3);
      setp(8'h0A, 3);
      setp(8'h03, 2);
      for (i = 1; i < 3; i++)
      begin
         @(negedge core_clk);
         ek = -1;
         hw_mode_pin = 1'b1;
         hw_pattern_pin = i[1:0];
         repeat (12) @(negedge core_clk);
         ek = (i == 1) ? 0 : 3;
         nh = 0;
         repeat (120) @(negedge core_clk);
      end
      // Pins and register pattern swap over mid-stream, so stop comparing first
      ek = -1;
      hw_pattern_pin = 2'b00;
      hw_mode_pin = 1'b0;
      // Sequence looped back to the receiver
      sequence_event_mask = 1'b1;
      lmode = 2'd2;
      setp(8'h02, 3);
      v = 8'h00;
      for (i = 0; i < 40 && v[2] !== 1'b1; i++)
      begin
         repeat (50) @(posedge core_clk);
         rd(LAPM_LINE_STATUS_ZERO_OFS);
      end
      cmp("seq_sync", 8'h01, {7'd0, v[2]});
      cmp("seq_irq_rise", 8'h01, {7'd0, seq_irq});
      sequence_event_clear = 1'b1;
      @(negedge core_clk);
      sequence_event_clear = 1'b0;
      sequence_event_edge_select = 1'b1;
      @(negedge core_clk);
      cmp("seq_irq_clr", 8'h00, {7'd0, seq_irq});
      lmode = 2'd1;
      repeat (800) @(posedge core_clk);
      rd(LAPM_LINE_STATUS_ZERO_OFS);
      cmp("seq_lost", 8'h00, {7'd0, v[2]});
      cmp("seq_irq_fall", 8'h01, {7'd0, seq_irq});
      // Loss declare at both counts, then clear
      for (i = 0; i < 2; i++)
      begin
         n = (i == 1) ? 2048 : 32;
         setp(i[0] ? 8'h10 : 8'h00, 2);
         lmode = 2'd0;
         ticks(n - 1);
         repeat (2) @(posedge core_clk);
         cmp("loss_early", 8'h00, {7'd0, loss_out});
         ticks(1);
         repeat (2) @(posedge core_clk);
         cmp("loss_out", 8'h01, {7'd0, loss_out});
         cmp("los_irq", 8'h01, {7'd0, los_irq});
         los_irq_mask = 1'b1;
         #1;
         cmp("los_irq_mask", 8'h00, {7'd0, los_irq});
         los_irq_mask = 1'b0;
         setp(i[0] ? 8'h30 : 8'h20, 2);
         rk = 1;
         repeat (80) @(posedge core_clk);
         rk = -1;
         setp(i[0] ? 8'h50 : 8'h40, 0);
         setp(i[0] ? 8'h10 : 8'h00, 2);
         rk = 0;
         @(negedge core_clk);
         line_monitor_mode = 1'b1;
         repeat (3) @(negedge core_clk);
         cmp("loss_monitor", 8'h00, {7'd0, loss_out});
         line_monitor_mode = 1'b0;
         repeat (3) @(posedge core_clk);
         rk = -1;
         lmode = 2'd1;
         ticks(30);
         repeat (2) @(posedge core_clk);
         cmp("loss_held", 8'h01, {7'd0, loss_out});
         ticks(2);
         repeat (3) @(negedge core_clk);
         cmp("loss_clear", 8'h00, {7'd0, loss_out});
      end
      // Alarm signal: single block criterion, then two blocks
      cdr_enable = 1'b0;
      ticks(1100);
      rd(LAPM_LINE_STATUS_ZERO_OFS);
      cmp("ais_no_cdr", 8'h00, {7'd0, v[1]});
      cdr_enable = 1'b1;
      ticks(1100);
      rd(LAPM_LINE_STATUS_ZERO_OFS);
      cmp("ais_one_blk", 8'h01, {7'd0, v[1]});
      lmode = 2'd0;
      ticks(1100);
      rd(LAPM_LINE_STATUS_ZERO_OFS);
      cmp("ais_clear", 8'h00, {7'd0, v[1]});
      setp(8'h00, 2);
      lmode = 2'd1;
      // Two low blocks cannot both end before 1022 ticks, whatever the block phase
      ticks(1020);
      rd(LAPM_LINE_STATUS_ZERO_OFS);
      cmp("ais_wait_two", 8'h00, {7'd0, v[1]});
      ticks(580);
      rd(LAPM_LINE_STATUS_ZERO_OFS);
      cmp("ais_two_blk", 8'h01, {7'd0, v[1]});
      results();
   end
endmodule // test_lapm_monitor
`default_nettype wire
